// [src/gpp_pin_det.sv]
`timescale 1ns/1ps
module gpp_pin_det (
  // clock and reset
  input logic clk,
  input logic rst_b,
  // raw pad levels, enable gating and trigger types
  input logic [7:0] pin_in,
  input logic [7:0] den,
  input gpp_pkg::gpp_itype_t itype [8],
  // synchronised level and detection hits
  output logic [7:0] pin_lvl,
  output logic [7:0] int_hit
);
  logic [7:0] s1_ff; // first stage, read only by s2_ff
  logic [7:0] s2_ff; // second stage
  logic [7:0] lvl_ff; // gated level
  logic [7:0] prev_ff; // level one cycle earlier

  // one pin's trigger test
  function automatic logic det(input gpp_pkg::gpp_itype_t t, input logic cur, input logic old);
    unique case (t)
      gpp_pkg::int_falling: det = old & ~cur;
      gpp_pkg::int_rising: det = ~old & cur;
      gpp_pkg::int_both: det = old ^ cur;
      gpp_pkg::int_low: det = ~cur;
      gpp_pkg::int_high: det = cur;
      default: det = 1'b0;
    endcase
  endfunction

  // two-flop synchroniser, then digital enable gating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      lvl_ff <= 8'h00;
      prev_ff <= 8'h00;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      lvl_ff <= s2_ff & den; // RULE15
      prev_ff <= lvl_ff;
    end
  end

  // edge and level detection per pin
  always_comb begin
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      int_hit[i] = det(itype[i], lvl_ff[i], prev_ff[i]); // RULE16
    end
  end

  assign pin_lvl = lvl_ff;
endmodule

// [src/gpp_pkg.sv]
package gpp_pkg;
  // pin count and bus widths
  localparam int NPINS = 8;
  localparam int AW = 12;
  localparam int DW = 32;
  // masked pin data window: address bits 9:2 carry the pin selection
  localparam logic [1:0] DATA_WIN = 2'h0;
  localparam int DATA_MASK_LSB = 2;
  // command and status registers
  localparam logic [11:0] OFS_DIR = 12'h400;
  localparam logic [11:0] OFS_ITYPE = 12'h404;
  localparam logic [11:0] OFS_PAD = 12'h408;
  localparam logic [11:0] OFS_INT_CLR = 12'h40C;
  localparam logic [11:0] OFS_INT_DIS = 12'h410;
  localparam logic [11:0] OFS_INT_EN = 12'h414;
  localparam logic [11:0] OFS_RAW_STAT = 12'h418;
  localparam logic [11:0] OFS_MSK_STAT = 12'h41C;
  localparam logic [11:0] OFS_DEN = 12'h420;
  // per-pin readback block, one word per pin
  localparam logic [11:0] OFS_PCFG = 12'h440;
  localparam logic [11:0] OFS_PCFG_END = 12'h45C;
  // command word fields: low byte is the pin selection, value above it
  localparam int CMD_MASK_LSB = 0;
  localparam int CMD_VAL_LSB = 8;
  localparam int PAD_SET_LSB = 12;
  // readback word field positions
  localparam int PCFG_DIR_LSB = 0;
  localparam int PCFG_DRV_LSB = 2;
  localparam int PCFG_PAD_LSB = 4;
  localparam int PCFG_ITYPE_LSB = 7;
  localparam int PCFG_DEN_LSB = 10;
  // pin direction and ownership
  typedef enum logic [1:0] {dir_sw_input, dir_sw_output, dir_peripheral_owned} gpp_dir_t;
  // drive strength choices
  typedef enum logic [1:0] {drive_level_low, drive_level_mid, drive_level_high,
                            drive_level_high_slew_limited} gpp_drive_t;
  // pad type choices
  typedef enum logic [2:0] {pad_push_pull, pad_push_pull_pullup, pad_push_pull_pulldown, pad_open_drain,
                            pad_open_drain_pullup, pad_open_drain_pulldown, pad_analog} gpp_pad_t;
  // interrupt detection choices
  typedef enum logic [2:0] {int_falling, int_rising, int_both, int_low, int_high} gpp_itype_t;
  // highest legal codes, larger writes are ignored
  localparam logic [1:0] DIR_MAX = 2'h2;
  localparam logic [2:0] PAD_MAX = 3'h6;
  localparam logic [2:0] ITYPE_MAX = 3'h4;
  // values after reset
  localparam gpp_dir_t DIR_RST = dir_sw_input;
  localparam gpp_drive_t DRV_RST = drive_level_low;
  localparam gpp_pad_t PAD_RST = pad_push_pull;
  localparam gpp_itype_t ITYPE_RST = int_falling;
  localparam logic [7:0] DEN_RST = 8'h00;
  localparam logic [7:0] IM_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // pad control bundle for one pin
  typedef struct packed {
    logic [1:0] strength;
    logic slew_limit;
    logic open_drain;
    logic pull_up;
    logic pull_down;
    logic analog;
  } gpp_pad_ctl_t;
  // stored configuration for one pin
  typedef struct packed {
    gpp_dir_t dir;
    gpp_drive_t drive;
    gpp_pad_t pad;
    gpp_itype_t itype;
  } gpp_pin_cfg_t;
endpackage

// [src/gpp_port.sv]
// Notes on behaviour
// [RULE1] drive strength low, mid or high per pin
// [RULE2] high drive with slew limiting option
// [RULE3] push-pull or open-drain, pulls, or analog
// [RULE4] input pins store pad setting, pulls act
// [RULE5] drive and pad type read back per pin
// [RULE6] eight-bit selection mask, bit n is pin n
// [RULE7] clear pending interrupt of selected pins only
// [RULE8] software clears interrupt early in handler
// [RULE9] disabling pin removes it from interrupt output
// [RULE10] enabling pin lets pending drive output again
// [RULE11] raw and masked interrupt status views
// [RULE12] status one bit per pin, upper bits zero
// [RULE13] data read returns real pin level
// [RULE14] unselected bits of data read are zero
// [RULE15] digital input enable resets off
// [RULE16] edge or level interrupt detection per pin
// [RULE17] pin is input, output or peripheral owned
// [RULE18] data write to input pin has no effect
// [RULE19] address bits select pins for data access
// [RULE20] masked equals raw and enable, output ORs them
// [RULE21] exactly eight independent pins
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module gpp_port (
  // clock and reset
  input logic clk,
  input logic rst_b,
  // register port
  input logic [11:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  // package pins
  input logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output gpp_pkg::gpp_pad_ctl_t [7:0] pad_ctl,
  // peripheral side of owned pins
  input logic [7:0] periph_out,
  input logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  // port interrupt
  output logic irq
);
  gpp_pkg::gpp_pin_cfg_t cfg_ff [8]; // per-pin configuration
  gpp_pkg::gpp_itype_t itype_w [8]; // detection type to detector
  logic [7:0] den_ff; // digital input enable
  logic [7:0] data_ff; // software output data
  logic [7:0] im_ff; // interrupt enable
  logic [7:0] ris_ff; // raw pending status
  logic [7:0] mis; // masked status
  logic irq_ff; // registered interrupt output
  logic [7:0] pin_out_ff;
  logic [7:0] pin_oe_ff;
  logic [7:0] nxt_pin_out;
  logic [7:0] nxt_pin_oe;
  gpp_pkg::gpp_pad_ctl_t [7:0] pad_ctl_ff;
  gpp_pkg::gpp_pad_ctl_t [7:0] nxt_pad_ctl;
  logic [7:0] periph_in_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] pin_lvl; // synchronised, enabled pin level
  logic [7:0] int_hit; // detection this cycle
  logic [7:0] cmd_mask; // selection byte of a command write
  logic [7:0] data_mask; // selection from data window address
  logic data_hit; // access falls in data window
  logic [7:0] clr_vec; // pins cleared this cycle

  // register address compare
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // selection and window decode
  assign cmd_mask = reg_wdata[gpp_pkg::CMD_MASK_LSB +: 8]; // RULE6
  assign data_mask = reg_addr[gpp_pkg::DATA_MASK_LSB +: 8]; // RULE19
  assign data_hit = (reg_addr[11:10] == gpp_pkg::DATA_WIN);
  assign clr_vec = (reg_wr && hit(reg_addr, gpp_pkg::OFS_INT_CLR)) ? cmd_mask : 8'h00;

  // detection type handed to the detector
  always_comb begin
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      itype_w[i] = cfg_ff[i].itype;
    end
  end

  // synchroniser and trigger detection
  gpp_pin_det gpp_pin_det_inst (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(pin_in),
    .den(den_ff),
    .itype(itype_w),
    .pin_lvl(pin_lvl),
    .int_hit(int_hit)
  );

  // per-pin configuration commands
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < gpp_pkg::NPINS; i++) begin
        cfg_ff[i].dir <= gpp_pkg::DIR_RST;
        cfg_ff[i].drive <= gpp_pkg::DRV_RST;
        cfg_ff[i].pad <= gpp_pkg::PAD_RST;
        cfg_ff[i].itype <= gpp_pkg::ITYPE_RST;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < gpp_pkg::NPINS; i++) begin
        if (cmd_mask[i]) begin // RULE6
          // direction and ownership
          if (hit(reg_addr, gpp_pkg::OFS_DIR) && reg_wdata[gpp_pkg::CMD_VAL_LSB +: 2] <= gpp_pkg::DIR_MAX) begin
            cfg_ff[i].dir <= gpp_pkg::gpp_dir_t'(reg_wdata[gpp_pkg::CMD_VAL_LSB +: 2]); // RULE17
          end
          // trigger type
          if (hit(reg_addr, gpp_pkg::OFS_ITYPE) && reg_wdata[gpp_pkg::CMD_VAL_LSB +: 3] <= gpp_pkg::ITYPE_MAX) begin
            cfg_ff[i].itype <= gpp_pkg::gpp_itype_t'(reg_wdata[gpp_pkg::CMD_VAL_LSB +: 3]); // RULE16
          end
          // pad settings kept whatever the direction
          if (hit(reg_addr, gpp_pkg::OFS_PAD) && reg_wdata[gpp_pkg::PAD_SET_LSB +: 3] <= gpp_pkg::PAD_MAX) begin
            cfg_ff[i].drive <= gpp_pkg::gpp_drive_t'(reg_wdata[gpp_pkg::CMD_VAL_LSB +: 2]); // RULE1 RULE2
            cfg_ff[i].pad <= gpp_pkg::gpp_pad_t'(reg_wdata[gpp_pkg::PAD_SET_LSB +: 3]); // RULE3 RULE4
          end
        end
      end
    end
  end

  // digital input enable, off after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      den_ff <= gpp_pkg::DEN_RST; // RULE15
    end else if (reg_wr && hit(reg_addr, gpp_pkg::OFS_DEN)) begin
      den_ff <= reg_wdata[gpp_pkg::CMD_VAL_LSB] ? (den_ff | cmd_mask) : (den_ff & ~cmd_mask);
    end
  end

  // masked data write, only output pins take it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_ff <= gpp_pkg::DATA_RST;
    end else if (reg_wr && data_hit) begin
      for (int i = 0; i < gpp_pkg::NPINS; i++) begin
        if (data_mask[i] && cfg_ff[i].dir == gpp_pkg::dir_sw_output) begin // RULE18 RULE19
          data_ff[i] <= reg_wdata[i];
        end
      end
    end
  end

  // interrupt enable: enable sets, disable clears
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      im_ff <= gpp_pkg::IM_RST;
    end else if (reg_wr && hit(reg_addr, gpp_pkg::OFS_INT_EN)) begin
      im_ff <= im_ff | cmd_mask; // RULE10
    end else if (reg_wr && hit(reg_addr, gpp_pkg::OFS_INT_DIS)) begin
      im_ff <= im_ff & ~cmd_mask; // RULE9
    end
  end

  // raw status: a new hit wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ris_ff <= 8'h00;
    end else begin
      ris_ff <= int_hit | (ris_ff & ~clr_vec); // RULE7 RULE21
    end
  end

  // masked view and combined output
  assign mis = ris_ff & im_ff; // RULE20
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |mis; // RULE20
    end
  end

  // pad drive decision per pin
  always_comb begin
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      logic d;
      logic en;
      logic od;
      d = 1'b0;
      en = 1'b0;
      od = (cfg_ff[i].pad == gpp_pkg::pad_open_drain) || (cfg_ff[i].pad == gpp_pkg::pad_open_drain_pullup) ||
           (cfg_ff[i].pad == gpp_pkg::pad_open_drain_pulldown);
      unique case (cfg_ff[i].dir) // RULE17
        gpp_pkg::dir_sw_output: begin
          d = data_ff[i];
          en = 1'b1;
        end
        gpp_pkg::dir_peripheral_owned: begin
          d = periph_out[i];
          en = periph_oe[i];
        end
        default: begin
          d = 1'b0;
          en = 1'b0;
        end
      endcase
      // analog pads never drive
      if (cfg_ff[i].pad == gpp_pkg::pad_analog) begin
        en = 1'b0;
      end
      // open drain pulls low only
      nxt_pin_out[i] = od ? 1'b0 : d; // RULE3
      nxt_pin_oe[i] = od ? (en & ~d) : en; // RULE3
      nxt_pad_ctl[i].strength = cfg_ff[i].drive == gpp_pkg::drive_level_high_slew_limited ?
                                2'(gpp_pkg::drive_level_high) : 2'(cfg_ff[i].drive); // RULE1
      nxt_pad_ctl[i].slew_limit = (cfg_ff[i].drive == gpp_pkg::drive_level_high_slew_limited); // RULE2
      nxt_pad_ctl[i].open_drain = od;
      nxt_pad_ctl[i].pull_up = (cfg_ff[i].pad == gpp_pkg::pad_push_pull_pullup) ||
                               (cfg_ff[i].pad == gpp_pkg::pad_open_drain_pullup); // RULE4
      nxt_pad_ctl[i].pull_down = (cfg_ff[i].pad == gpp_pkg::pad_push_pull_pulldown) ||
                                 (cfg_ff[i].pad == gpp_pkg::pad_open_drain_pulldown); // RULE4
      nxt_pad_ctl[i].analog = (cfg_ff[i].pad == gpp_pkg::pad_analog);
    end
  end

  // registered pad outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_out_ff <= 8'h00;
      pin_oe_ff <= 8'h00;
      pad_ctl_ff <= '0;
      periph_in_ff <= 8'h00;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
      pad_ctl_ff <= nxt_pad_ctl;
      periph_in_ff <= pin_lvl;
    end
  end

  // read decode
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (data_hit) begin
        nxt_rdata = {24'h00_0000, pin_lvl & data_mask}; // RULE13 RULE14
      end else if (hit(reg_addr, gpp_pkg::OFS_RAW_STAT)) begin
        nxt_rdata = {24'h00_0000, ris_ff}; // RULE11 RULE12
      end else if (hit(reg_addr, gpp_pkg::OFS_MSK_STAT)) begin
        nxt_rdata = {24'h00_0000, mis}; // RULE11 RULE12
      end else if (hit(reg_addr, gpp_pkg::OFS_INT_EN)) begin
        nxt_rdata = {24'h00_0000, im_ff};
      end else if (hit(reg_addr, gpp_pkg::OFS_DEN)) begin
        nxt_rdata = {24'h00_0000, den_ff};
      end else if (reg_addr >= gpp_pkg::OFS_PCFG && reg_addr <= gpp_pkg::OFS_PCFG_END && reg_addr[1:0] == 2'h0) begin
        // per-pin readback word
        for (int i = 0; i < gpp_pkg::NPINS; i++) begin
          if (reg_addr[4:2] == 3'(i)) begin
            nxt_rdata[gpp_pkg::PCFG_DIR_LSB +: 2] = cfg_ff[i].dir;
            nxt_rdata[gpp_pkg::PCFG_DRV_LSB +: 2] = cfg_ff[i].drive; // RULE5
            nxt_rdata[gpp_pkg::PCFG_PAD_LSB +: 3] = cfg_ff[i].pad; // RULE5
            nxt_rdata[gpp_pkg::PCFG_ITYPE_LSB +: 3] = cfg_ff[i].itype;
            nxt_rdata[gpp_pkg::PCFG_DEN_LSB] = den_ff[i];
          end
        end
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign pad_ctl = pad_ctl_ff;
  assign periph_in = periph_in_ff;
  assign irq = irq_ff;

  // helper: pins that are analog or inputs
  logic [7:0] quiet_mask;
  always_comb begin
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      quiet_mask[i] = (cfg_ff[i].pad == gpp_pkg::pad_analog) || (cfg_ff[i].dir == gpp_pkg::dir_sw_input);
    end
  end

  // helper: pins that take no data write, inputs and peripheral owned
  logic [7:0] no_data_mask;
  always_comb begin
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      no_data_mask[i] = (cfg_ff[i].dir != gpp_pkg::dir_sw_output);
    end
  end

  data_in_hold_a: // RULE18
    assert property (@(posedge clk) disable iff (!rst_b)
      (reg_wr && data_hit) |=> ((data_ff ^ $past(data_ff)) & $past(no_data_mask)) == 8'h00)
    else $error("data write changed an input pin");
  int_clear_sel_a: // RULE7
    assert property (@(posedge clk) disable iff (!rst_b)
      (clr_vec != 8'h00) |=> ((ris_ff & $past(clr_vec) & ~$past(int_hit)) == 8'h00))
    else $error("selected pending bit survived clear");
  int_clear_keep_a: // RULE7
    assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> (ris_ff & $past(ris_ff)) == ($past(ris_ff) & (~$past(clr_vec) | $past(int_hit))))
    else $error("unselected pending bit lost");
  int_disable_a: // RULE9
    assert property (@(posedge clk) disable iff (!rst_b)
      (reg_wr && hit(reg_addr, gpp_pkg::OFS_INT_DIS) && cmd_mask == 8'hFF) ##1 !(reg_wr && hit(reg_addr,
      gpp_pkg::OFS_INT_EN)) |=> !irq)
    else $error("interrupt still out after full disable");
  int_enable_a: // RULE10
    assert property (@(posedge clk) disable iff (!rst_b)
      (reg_wr && hit(reg_addr, gpp_pkg::OFS_INT_EN) && (ris_ff & cmd_mask) != 8'h00 && clr_vec == 8'h00)
      |=> ##1 irq)
    else $error("enabled pending pin did not raise interrupt");
  irq_or_a: // RULE20
    assert property (@(posedge clk) disable iff (!rst_b) ##1 irq == $past(|(ris_ff & im_ff)))
    else $error("interrupt output not OR of masked status");
  read_mask_a: // RULE14
    assert property (@(posedge clk) disable iff (!rst_b)
      (reg_rd && data_hit) |=> (reg_rdata & ~{24'hFF_FFFF, $past(data_mask)}) == 32'h0000_0000)
    else $error("unselected data bit read as one");
  stat_upper_a: // RULE12
    assert property (@(posedge clk) disable iff (!rst_b)
      (reg_rd && (hit(reg_addr, gpp_pkg::OFS_RAW_STAT) || hit(reg_addr, gpp_pkg::OFS_MSK_STAT)))
      |=> reg_rdata[31:8] == 24'h00_0000 && reg_rdata[7:0] == $past(hit(reg_addr, gpp_pkg::OFS_RAW_STAT) ?
      ris_ff : mis))
    else $error("status word wrong");
  quiet_pin_a: // RULE3
    assert property (@(posedge clk) disable iff (!rst_b) ##1 (pin_oe & $past(quiet_mask)) == 8'h00)
    else $error("analog or input pin drove");
  rdata_idle_a: // RULE13
    assert property (@(posedge clk) disable iff (!rst_b) !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data without strobe");

  edge_irq_c: cover property (@(posedge clk) disable iff (!rst_b) (|int_hit) ##2 irq);
  masked_read_c: cover property (@(posedge clk) disable iff (!rst_b) reg_rd && data_hit && data_mask != 8'hFF);
  od_low_c: cover property (@(posedge clk) disable iff (!rst_b) |(pin_oe & ~pin_out & {8{pad_ctl[0].open_drain}}));
  clr_race_c: cover property (@(posedge clk) disable iff (!rst_b) |(clr_vec & int_hit));
endmodule

// [test/gpp_pin_model.sv]
`timescale 1ns/1ps
module gpp_pin_model (
  // clock
  input wire logic clk,
  // device drive
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire gpp_pkg::gpp_pad_ctl_t [7:0] pad_ctl,
  // board drive
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  // resolved pin level
  output logic [7:0] pin_lvl
);
  logic [7:0] float_ff = 8'h5A; // undriven pins wander
  // a floating pin never holds a steady level
  always @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // device first, then board, then weak pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_drv[i]) pin_lvl[i] = ext_val[i];
      else if (pad_ctl[i].pull_up) pin_lvl[i] = 1'b1;
      else if (pad_ctl[i].pull_down) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = float_ff[i];
    end
  end
endmodule

// [test/gpp_port_tb.sv]
`timescale 1ns/1ps
module gpp_port_tb;
  // bus side
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // pin side
  logic [7:0] pin_lvl, pin_out, pin_oe, periph_in;
  gpp_pkg::gpp_pad_ctl_t [7:0] pad_ctl;
  logic [7:0] periph_out = 8'h00;
  logic [7:0] periph_oe = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_drv = 8'hFF;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  int seed = 88316;
  // reference copy of pin state
  logic [1:0] dir_m [8] = '{default: 2'h0};
  logic [1:0] drv_m [8] = '{default: 2'h0};
  logic [2:0] pad_m [8] = '{default: 3'h0};
  logic [2:0] ity_m [8] = '{default: 3'h0};
  logic [7:0] data_m = 8'h00;
  logic [7:0] den_m = 8'h00;
  logic [7:0] m, e, c, st;

  gpp_port gpp_port_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pad_ctl(pad_ctl), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .irq(irq));
  gpp_pin_model gpp_pin_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad_ctl(pad_ctl),
    .ext_val(ext_val), .ext_drv(ext_drv), .pin_lvl(pin_lvl));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic set_dir(input logic [7:0] mk, input logic [1:0] v);
    wr(gpp_pkg::OFS_DIR, {22'h0, v, mk});
    for (int i = 0; i < 8; i++) if (mk[i]) dir_m[i] = v;
  endtask
  task automatic set_pad(input logic [7:0] mk, input logic [1:0] dv, input logic [2:0] pd);
    wr(gpp_pkg::OFS_PAD, {17'h0, pd, 2'h0, dv, mk});
    for (int i = 0; i < 8; i++) if (mk[i]) begin
      drv_m[i] = dv;
      pad_m[i] = pd;
    end
  endtask
  task automatic wr_data(input logic [7:0] mk, input logic [7:0] d);
    wr({2'h0, mk, 2'h0}, {24'h0, d});
    for (int i = 0; i < 8; i++) if (mk[i] && dir_m[i] == 2'h1) data_m[i] = d[i];
  endtask
  // expected pad control bundle of one pin
  function automatic logic [31:0] exp_pad(input int i);
    exp_pad = {25'h0, drv_m[i] == 2'h3 ? 2'h2 : drv_m[i], drv_m[i] == 2'h3, pad_m[i] >= 3'h3 && pad_m[i] <= 3'h5,
      pad_m[i] == 3'h1 || pad_m[i] == 3'h4, pad_m[i] == 3'h2 || pad_m[i] == 3'h5, pad_m[i] == 3'h6};
  endfunction
  function automatic logic [7:0] exp_oe();
    for (int i = 0; i < 8; i++)
      exp_oe[i] = dir_m[i] == 2'h1 ? (pad_m[i] >= 3'h3 ? ~data_m[i] : 1'b1) : (dir_m[i] == 2'h2 && periph_oe[i]);
  endfunction
  function automatic logic [7:0] exp_out();
    for (int i = 0; i < 8; i++)
      exp_out[i] = dir_m[i] == 2'h1 ? (pad_m[i] < 3'h3 && data_m[i]) : periph_out[i];
  endfunction
  // board drives every pin that the device leaves alone
  function automatic logic [7:0] exp_lvl();
    exp_lvl = (exp_oe() & exp_out()) | (~exp_oe() & ext_val);
  endfunction
  // all per-pin readback words and pad outputs
  task automatic check_cfg();
    for (int i = 0; i < 8; i++) begin
      rd_chk("pin_cfg", gpp_pkg::OFS_PCFG + 12'(4 * i), {21'h0, den_m[i], ity_m[i], pad_m[i], drv_m[i], dir_m[i]});
      chk("pad_ctl", exp_pad(i), {25'h0, pad_ctl[i]});
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("pin_oe", 32'h0, {24'h0, pin_oe});
    chk("irq", 32'h0, {31'h0, irq});
    ext_val <= 8'hFF;
    repeat (6) @(posedge clk);
    rd_chk("data_den_off", 12'h3FC, 32'h0);
    rd_chk("den", gpp_pkg::OFS_DEN, 32'h0);
    rd_chk("unmapped", 12'h500, 32'h0);
    rd_chk("dir_cmd", gpp_pkg::OFS_DIR, 32'h0);
    check_cfg();
    wr(gpp_pkg::OFS_DEN, 32'h1FF);
    den_m = 8'hFF;
    // every drive and pad code on random pin groups
    for (int k = 0; k < 28; k++) begin
      set_pad(8'($random(seed)) | (8'h01 << k[2:0]), k[1:0], k[4:2]);
      check_cfg();
    end
    wr(gpp_pkg::OFS_DIR, 32'h3FF);
    check_cfg();
    // input pins with no board drive follow the weak pulls
    ext_drv <= 8'h00;
    set_pad(8'hFF, 2'h0, 3'h1);
    repeat (6) @(posedge clk);
    rd_chk("pull_up", 12'h3FC, 32'hFF);
    set_pad(8'hFF, 2'h0, 3'h2);
    repeat (6) @(posedge clk);
    rd_chk("pull_down", 12'h3FC, 32'h0);
    set_pad(8'hFF, 2'h0, 3'h0);
    ext_drv <= 8'hFF;
    // pin 7 stays with the peripheral, others move randomly
    set_dir(8'h80, 2'h2);
    for (int k = 0; k < 12; k++) begin
      set_dir(8'($random(seed)) & 8'h7F, 2'($random(seed) & 1));
      set_pad(8'($random(seed)) & 8'h7F, 2'h0, ($random(seed) & 1) ? 3'h3 : 3'h0);
      wr_data(8'($random(seed)), 8'($random(seed)));
      ext_val <= 8'($random(seed));
      periph_out <= 8'($random(seed));
      periph_oe <= 8'($random(seed));
      m = 8'($random(seed));
      repeat (6) @(posedge clk);
      chk("pin_oe", {24'h0, exp_oe()}, {24'h0, pin_oe});
      chk("pin_out", {24'h0, exp_oe() & exp_out()}, {24'h0, pin_oe & pin_out});
      chk("periph_in", {24'h0, exp_lvl()}, {24'h0, periph_in});
      rd_chk("pin_data", {2'h0, m, 2'h0}, {24'h0, exp_lvl() & m});
    end
    // every detection type, then enable, clear and disable
    set_dir(8'h7F, 2'h0);
    periph_oe <= 8'h00;
    for (int t = 0; t < 5; t++) begin
      st = (t == 0 || t == 3) ? 8'hFF : 8'h00;
      ext_val <= st;
      wr(gpp_pkg::OFS_ITYPE, {21'h0, 3'(t), 8'hFF});
      for (int i = 0; i < 8; i++) ity_m[i] = 3'(t);
      check_cfg();
      wr(gpp_pkg::OFS_INT_CLR, 32'hFF);
      wr(gpp_pkg::OFS_INT_DIS, 32'hFF);
      rd_chk("raw_idle", gpp_pkg::OFS_RAW_STAT, 32'h0);
      m = 8'($random(seed)) | 8'h01;
      ext_val <= st ^ m;
      repeat (6) @(posedge clk);
      rd_chk("raw_hit", gpp_pkg::OFS_RAW_STAT, {24'h0, m});
      e = 8'($random(seed));
      wr(gpp_pkg::OFS_INT_EN, {24'h0, e});
      repeat (2) @(posedge clk);
      chk("irq_en", {31'h0, |(m & e)}, {31'h0, irq});
      rd_chk("masked", gpp_pkg::OFS_MSK_STAT, {24'h0, m & e});
      rd_chk("int_en", gpp_pkg::OFS_INT_EN, {24'h0, e});
      c = 8'($random(seed));
      wr(gpp_pkg::OFS_INT_CLR, {24'h0, c});
      repeat (2) @(posedge clk);
      rd_chk("raw_clr", gpp_pkg::OFS_RAW_STAT, {24'h0, t >= 3 ? m : m & ~c});
      wr(gpp_pkg::OFS_INT_DIS, 32'hFF);
      repeat (2) @(posedge clk);
      chk("irq_dis", 32'h0, {31'h0, irq});
    end
    // clearing the digital input enable hides those pins again
    ext_val <= 8'hFF;
    wr(gpp_pkg::OFS_DEN, 32'h0F);
    den_m = 8'hF0;
    repeat (6) @(posedge clk);
    rd_chk("den_clr", 12'h3FC, 32'hF0);
    rd_chk("den_rd", gpp_pkg::OFS_DEN, 32'hF0);
    report_and_stop();
  end
endmodule
